// *** src/mst_pkg.sv ***
// constants for the microstep translator and gate sequencer
package mst_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int TIMEBASE_HZ = 4_000_000;
  // master timebase enable divider, rounded down so the timebase runs no slower
  localparam int TIMEBASE_DIV = CLK_HZ / TIMEBASE_HZ;
  localparam logic [2:0] TIMEBASE_LAST = 3'(TIMEBASE_DIV - 1);

  // all in master timebase periods
  localparam logic [6:0] OFF_TICKS = 7'h57;
  localparam logic [2:0] BLANK_TICKS = 3'h6;
  localparam logic [1:0] GAP_TICKS = 2'h3;

  // fast-decay share of the off-time, indexed by {fastDecayShareHigh, fastDecayShareLow}
  localparam logic [6:0] FAST_TICKS_0 = 7'h00;
  localparam logic [6:0] FAST_TICKS_1 = 7'h0D;
  localparam logic [6:0] FAST_TICKS_2 = 7'h2A;
  localparam logic [6:0] FAST_TICKS_3 = 7'h57;

  // phase index: 64 positions over one electrical turn
  localparam logic [5:0] HOME_INDEX = 6'h08;
  // both bridges start in mixed decay
  localparam logic [1:0] DECAY_HOME = 2'h3;
  localparam logic [5:0] STRIDE_FULL = 6'h10;
  localparam logic [5:0] STRIDE_HALF = 6'h08;
  localparam logic [5:0] STRIDE_QUARTER = 6'h04;
  localparam logic [5:0] STRIDE_SIXTEENTH = 6'h01;
  localparam logic [5:0] QUARTER_TURN = 6'h10;

  // resolution code {microstepSelectHigh, microstepSelectLow}
  localparam logic [1:0] RES_FULL = 2'h0;
  localparam logic [1:0] RES_HALF = 2'h1;
  localparam logic [1:0] RES_QUARTER = 2'h2;
  localparam logic [1:0] RES_SIXTEENTH = 2'h3;

  typedef enum logic [1:0] {
    MST_DRIVE,
    MST_FAST,
    MST_SLOW
  } mst_pwm_e;
endpackage : mst_pkg

// *** src/mst_translator_gate.sv ***
// step/direction microstep translator with two fixed off-time bridge sequencers
`timescale 1ns/1ps
module mst_translator_gate (
  input wire logic clk,
  input wire logic resetn,
  input wire logic step,
  input wire logic direction,
  input wire logic microstepSelectLow,
  input wire logic microstepSelectHigh,
  input wire logic fastDecayShareLow,
  input wire logic fastDecayShareHigh,
  input wire logic outputDisable,
  input wire logic gateSupplyLow,
  input wire logic [1:0] senseTrip,
  output logic [6:0] dacLevelOne,
  output logic [6:0] dacLevelTwo,
  output logic [1:0] windingPolarity,
  output logic [1:0] mixedDecay,
  output logic [5:0] phaseIndex,
  output logic [3:0] upperGateOut,
  output logic [3:0] lowerGateOut
);

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // magnitude of sine in 1/64 of full scale for a quarter-wave position 0..16
  function automatic logic [6:0] quarterWave(input logic [4:0] q);
    logic [6:0] m;
    m = 7'h00;
    unique case (q)
      5'h00: m = 7'h00;
      5'h01: m = 7'h06;
      5'h02: m = 7'h0C;
      5'h03: m = 7'h13;
      5'h04: m = 7'h18;
      5'h05: m = 7'h1E;
      5'h06: m = 7'h24;
      5'h07: m = 7'h29;
      5'h08: m = 7'h2D;
      5'h09: m = 7'h31;
      5'h0A: m = 7'h35;
      5'h0B: m = 7'h38;
      5'h0C: m = 7'h3B;
      5'h0D: m = 7'h3D;
      5'h0E: m = 7'h3F;
      default: m = 7'h40;
    endcase
    return m;
  endfunction : quarterWave

  // sine magnitude over a whole turn
  function automatic logic [6:0] sineMag(input logic [5:0] idx);
    logic [4:0] q;
    q = {1'b0, idx[3:0]};
    if (idx[4]) begin
      q = 5'h10 - q;
    end
    return quarterWave(q);
  endfunction : sineMag

  // positive current for the first half turn
  function automatic logic sinePositive(input logic [5:0] idx);
    return ~idx[5];
  endfunction : sinePositive

  // legs whose upper switch sources positive current
  function automatic logic [1:0] sourceLegs(input logic positive);
    return positive ? 2'h1 : 2'h2;
  endfunction : sourceLegs

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [7:0] pinMeta;
  logic [7:0] pinSync;
  logic stepLast;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pinMeta <= 8'h00;
      pinSync <= 8'h00;
      stepLast <= 1'b0;
    end else begin
      pinMeta <= {senseTrip, gateSupplyLow, outputDisable, fastDecayShareHigh, fastDecayShareLow,
                  direction, step};
      pinSync <= pinMeta;
      stepLast <= pinSync[0];
    end
  end

  logic stepEdge;
  logic [1:0] resolution;
  logic gatesBlocked;
  logic [1:0] fastShare;
  logic [1:0] tripSync;
  logic [1:0] msMeta;
  logic [1:0] msSync;

  // same two-flop latency as step, so a step sees settled select lines
  always_ff @(posedge clk) begin
    if (!resetn) begin
      msMeta <= 2'h0;
      msSync <= 2'h0;
    end else begin
      msMeta <= {microstepSelectHigh, microstepSelectLow};
      msSync <= msMeta;
    end
  end

  assign stepEdge = pinSync[0] & ~stepLast;
  assign resolution = msSync;
  assign fastShare = pinSync[3:2];
  assign gatesBlocked = pinSync[4] | pinSync[5];
  assign tripSync = pinSync[7:6];

  ////////////////////////////////////////////////////////////////////////////
  // master timebase enable

  logic [2:0] divCount;
  logic tick;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      divCount <= 3'h0;
      tick <= 1'b0;
    end else begin
      tick <= (divCount == mst_pkg::TIMEBASE_LAST);
      divCount <= (divCount == mst_pkg::TIMEBASE_LAST) ? 3'h0 : divCount + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // translator

  logic [5:0] stride;
  logic [5:0] next_phaseIndex;
  logic [5:0] cosIndex;

  // resolution sampled only with the step edge
  always_comb begin
    stride = mst_pkg::STRIDE_SIXTEENTH;
    unique case (resolution)
      mst_pkg::RES_FULL: stride = mst_pkg::STRIDE_FULL;
      mst_pkg::RES_HALF: stride = mst_pkg::STRIDE_HALF;
      mst_pkg::RES_QUARTER: stride = mst_pkg::STRIDE_QUARTER;
      mst_pkg::RES_SIXTEENTH: stride = mst_pkg::STRIDE_SIXTEENTH;
    endcase
  end

  // direction read only on the step edge
  assign next_phaseIndex = pinSync[1] ? phaseIndex - stride : phaseIndex + stride;
  assign cosIndex = next_phaseIndex + mst_pkg::QUARTER_TURN;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      phaseIndex <= mst_pkg::HOME_INDEX;
      dacLevelOne <= sineMag(mst_pkg::HOME_INDEX);
      dacLevelTwo <= sineMag(mst_pkg::HOME_INDEX + mst_pkg::QUARTER_TURN);
      windingPolarity <= {sinePositive(mst_pkg::HOME_INDEX + mst_pkg::QUARTER_TURN),
                          sinePositive(mst_pkg::HOME_INDEX)};
    end else if (stepEdge) begin
      phaseIndex <= next_phaseIndex;
      dacLevelOne <= sineMag(next_phaseIndex);
      dacLevelTwo <= sineMag(cosIndex);
      windingPolarity <= {sinePositive(cosIndex), sinePositive(next_phaseIndex)};
    end
  end

  // rising or equal level: slow decay
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mixedDecay <= mst_pkg::DECAY_HOME;
    end else if (stepEdge) begin
      mixedDecay <= {sineMag(cosIndex) < dacLevelTwo, sineMag(next_phaseIndex) < dacLevelOne};
    end
  end

  logic [6:0] fastTicks;

  always_comb begin
    fastTicks = mst_pkg::FAST_TICKS_0;
    unique case (fastShare)
      2'h0: fastTicks = mst_pkg::FAST_TICKS_0;
      2'h1: fastTicks = mst_pkg::FAST_TICKS_1;
      2'h2: fastTicks = mst_pkg::FAST_TICKS_2;
      2'h3: fastTicks = mst_pkg::FAST_TICKS_3;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-bridge off-time regulator and gate sequencing

  for (genvar b = 0; b < 2; b++) begin : gBridge
    mst_pkg::mst_pwm_e pwmState;
    logic [6:0] offCount;
    logic [2:0] blankCount;
    logic [1:0] wantUpper;
    logic [1:0] wantLower;
    logic settled;

    // the bridge has finished switching onto the wanted pattern
    assign settled = (upperGateOut[2*b +: 2] == wantUpper) && (lowerGateOut[2*b +: 2] == wantLower);

    always_ff @(posedge clk) begin
      if (!resetn) begin
        pwmState <= mst_pkg::MST_DRIVE;
        offCount <= 7'h00;
        blankCount <= mst_pkg::BLANK_TICKS;
      end else if (tick) begin
        unique case (pwmState)
          mst_pkg::MST_DRIVE: begin
            if (!settled) begin
              // blanking runs from the end of switching, so the gap cannot eat into it
              blankCount <= mst_pkg::BLANK_TICKS;
            end else if (blankCount != 3'h0) begin
              blankCount <= blankCount - 3'h1;
            end else if (tripSync[b]) begin
              offCount <= 7'h00;
              // share 0 leaves the bridge in slow decay
              if (mixedDecay[b] && fastTicks != mst_pkg::FAST_TICKS_0) begin
                pwmState <= mst_pkg::MST_FAST;
              end else begin
                pwmState <= mst_pkg::MST_SLOW;
              end
            end
          end
          mst_pkg::MST_FAST, mst_pkg::MST_SLOW: begin
            offCount <= offCount + 7'h01;
            if (offCount == mst_pkg::OFF_TICKS - 7'h01) begin
              pwmState <= mst_pkg::MST_DRIVE;
              blankCount <= mst_pkg::BLANK_TICKS;
            end else if (pwmState == mst_pkg::MST_FAST && offCount == fastTicks - 7'h01) begin
              pwmState <= mst_pkg::MST_SLOW;
            end
          end
          default: pwmState <= mst_pkg::MST_DRIVE;
        endcase
      end
    end

    // leg 0 high with leg 1 low drives positive current
    always_comb begin
      wantUpper = 2'h0;
      wantLower = 2'h0;
      unique case (pwmState)
        mst_pkg::MST_DRIVE: begin
          wantUpper = sourceLegs(windingPolarity[b]);
          wantLower = ~sourceLegs(windingPolarity[b]);
        end
        mst_pkg::MST_FAST: begin
          wantUpper = ~sourceLegs(windingPolarity[b]);
          wantLower = sourceLegs(windingPolarity[b]);
        end
        mst_pkg::MST_SLOW: begin
          // synchronous rectification through both lower switches
          wantLower = 2'h3;
        end
        default: begin
          wantUpper = 2'h0;
          wantLower = 2'h0;
        end
      endcase
    end

    for (genvar l = 0; l < 2; l++) begin : gLeg
      logic upperOn;
      logic lowerOn;
      logic [1:0] gapCount;

      // turn-off immediate, turn-on after the gap
      // upper gate high drives its switch on
      // lower gate high drives its switch on
      // disable forces off without waiting for a tick
      always_ff @(posedge clk) begin
        if (!resetn) begin
          upperOn <= 1'b0;
          lowerOn <= 1'b0;
          gapCount <= mst_pkg::GAP_TICKS;
        end else if (gatesBlocked) begin
          upperOn <= 1'b0;
          lowerOn <= 1'b0;
          gapCount <= mst_pkg::GAP_TICKS;
        end else if (tick) begin
          if ((upperOn && !wantUpper[l]) || (lowerOn && !wantLower[l])) begin
            upperOn <= upperOn & wantUpper[l];
            lowerOn <= lowerOn & wantLower[l];
            gapCount <= mst_pkg::GAP_TICKS - 2'h1;
          end else if (gapCount != 2'h0) begin
            gapCount <= gapCount - 2'h1;
          end else begin
            upperOn <= wantUpper[l];
            lowerOn <= wantLower[l];
          end
        end
      end

      assign upperGateOut[2*b+l] = upperOn;
      assign lowerGateOut[2*b+l] = lowerOn;
    end
  end

endmodule : mst_translator_gate

// *** verif/mst_step_ctrl.sv ***
// step and direction controller model
`timescale 1ns/1ps
module mst_step_ctrl (
  input wire logic clk,
  output logic step,
  output logic direction,
  output logic microstepSelectLow,
  output logic microstepSelectHigh
);
  initial begin
    step = 1'b0;
    direction = 1'b0;
    microstepSelectLow = 1'b0;
    microstepSelectHigh = 1'b0;
  end
  task automatic set_lines(input logic dir, input logic [1:0] res);
    @(posedge clk);
    direction <= dir;
    {microstepSelectHigh, microstepSelectLow} <= res;
  endtask : set_lines
  task automatic send_step(input logic dir, input logic [1:0] res, input int hold);
    set_lines(dir, res);
    repeat (2) @(posedge clk);
    step <= 1'b1;
    repeat (hold) @(posedge clk);
    step <= 1'b0;
    repeat (hold + 3) @(posedge clk);
  endtask : send_step
endmodule : mst_step_ctrl

// *** verif/mst_translator_gate_chk.sv ***
// port checks for the translator and gate sequencer
`timescale 1ns/1ps
module mst_translator_gate_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic step,
  input wire logic outputDisable,
  input wire logic gateSupplyLow,
  input wire logic [6:0] dacLevelOne,
  input wire logic [6:0] dacLevelTwo,
  input wire logic [1:0] windingPolarity,
  input wire logic [1:0] mixedDecay,
  input wire logic [5:0] phaseIndex,
  input wire logic [3:0] upperGateOut,
  input wire logic [3:0] lowerGateOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  home_state_a: assert property (disable iff (1'b0) !resetn |=> phaseIndex == mst_pkg::HOME_INDEX
    && dacLevelOne == 7'h2D && dacLevelTwo == 7'h2D && windingPolarity == 2'h3 && mixedDecay == 2'h3)
    else $error("bad home");
  no_shoot_a: assert property ((upperGateOut & lowerGateOut) == 4'h0)
    else $error("leg shorted");
  disable_off_a: assert property (outputDisable [*4] |-> (upperGateOut | lowerGateOut) == 4'h0)
    else $error("on while disabled");
  supply_off_a: assert property (gateSupplyLow [*4] |-> (upperGateOut | lowerGateOut) == 4'h0)
    else $error("on while supply low");
  step_cause_a: assert property ($changed(phaseIndex) |-> $past(step, 2) || $past(step, 3) || $past(step, 4))
    else $error("moved without step");
  stride_a: assert property ($changed(phaseIndex) |-> 6'(phaseIndex - $past(phaseIndex)) inside
    {6'h01, 6'h04, 6'h08, 6'h10, 6'h3F, 6'h3C, 6'h38, 6'h30}) else $error("bad stride");
  decay_pick_a: assert property ($changed(phaseIndex) |->
    mixedDecay == {dacLevelTwo < $past(dacLevelTwo), dacLevelOne < $past(dacLevelOne)}) else $error("bad decay");
  level_hold_a: assert property ($stable(phaseIndex) |-> $stable(dacLevelOne) && $stable(dacLevelTwo)
    && $stable(windingPolarity)) else $error("levels moved");
  // forced turn-off reloads the whole gap, so at least 18 clocks are owed; 12 are checked
  for (genvar l = 0; l < 4; l++) begin : g_leg
    gap_up_a: assert property ($fell(lowerGateOut[l]) |-> !upperGateOut[l] [*8] ##1 !upperGateOut[l] [*4])
      else $error("gap too short");
    gap_down_a: assert property ($fell(upperGateOut[l]) |-> !lowerGateOut[l] [*8] ##1 !lowerGateOut[l] [*4])
      else $error("lower gap too short");
  end
endmodule : mst_translator_gate_chk
bind mst_translator_gate mst_translator_gate_chk u_chk (.clk, .resetn, .step, .outputDisable, .gateSupplyLow,
  .dacLevelOne, .dacLevelTwo, .windingPolarity, .mixedDecay, .phaseIndex, .upperGateOut, .lowerGateOut);

// *** verif/tb.sv ***
// self-checking bench for the translator and gate sequencer
`timescale 1ns/1ps
module tb;
  localparam logic [6:0] QTAB [17] = '{7'h00, 7'h06, 7'h0C, 7'h13, 7'h18, 7'h1E, 7'h24, 7'h29, 7'h2D, 7'h31,
    7'h35, 7'h38, 7'h3B, 7'h3D, 7'h3F, 7'h40, 7'h40};
  localparam logic [5:0] STRIDE [4] = '{mst_pkg::STRIDE_FULL, mst_pkg::STRIDE_HALF, mst_pkg::STRIDE_QUARTER,
    mst_pkg::STRIDE_SIXTEENTH};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic step;
  logic direction;
  logic microstepSelectLow;
  logic microstepSelectHigh;
  logic fastDecayShareLow = 1'b0;
  logic fastDecayShareHigh = 1'b0;
  logic outputDisable = 1'b0;
  logic gateSupplyLow = 1'b0;
  logic [1:0] senseTrip = 2'h0;
  logic [6:0] dacLevelOne;
  logic [6:0] dacLevelTwo;
  logic [1:0] windingPolarity;
  logic [1:0] mixedDecay;
  logic [5:0] phaseIndex;
  logic [3:0] upperGateOut;
  logic [3:0] lowerGateOut;
  logic [5:0] expIdx = mst_pkg::HOME_INDEX;
  logic [1:0] expMix = 2'h3;
  int err_count = 0;
  int checks_done = 0;
  always #20 clk = ~clk;
  mst_step_ctrl ctrl (.clk, .step, .direction, .microstepSelectLow, .microstepSelectHigh);
  mst_translator_gate DUT (.clk, .resetn, .step, .direction, .microstepSelectLow, .microstepSelectHigh,
    .fastDecayShareLow, .fastDecayShareHigh, .outputDisable, .gateSupplyLow, .senseTrip, .dacLevelOne,
    .dacLevelTwo, .windingPolarity, .mixedDecay, .phaseIndex, .upperGateOut, .lowerGateOut);
  ////////////////////////////////////////////////////////////
  function automatic logic [6:0] mag(input logic [5:0] p);
    return (p[4:0] > 5'h10) ? QTAB[6'h20 - {1'b0, p[4:0]}] : QTAB[p[4:0]];
  endfunction : mag
  task automatic cmp(input string what, input logic [6:0] exp, input logic [6:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : cmp
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic check_state();
    logic [5:0] c;
    c = expIdx + 6'h10;
    cmp("index", {1'b0, expIdx}, {1'b0, phaseIndex});
    cmp("level one", mag(expIdx), dacLevelOne);
    cmp("level two", mag(c), dacLevelTwo);
    cmp("decay", {5'h0, expMix}, {5'h0, mixedDecay});
    // sign is undefined at a zero level
    if (mag(expIdx) != 7'h0)
      cmp("sign one", {6'h0, ~expIdx[5]}, {6'h0, windingPolarity[0]});
    if (mag(c) != 7'h0)
      cmp("sign two", {6'h0, ~c[5]}, {6'h0, windingPolarity[1]});
  endtask : check_state
  task automatic do_step(input logic dir, input logic [1:0] res);
    logic [6:0] o;
    logic [6:0] t;
    o = mag(expIdx);
    t = mag(expIdx + 6'h10);
    ctrl.send_step(dir, res, 2 + 6 * expIdx[0]);
    expIdx = dir ? expIdx - STRIDE[res] : expIdx + STRIDE[res];
    expMix = {mag(expIdx + 6'h10) < t, mag(expIdx) < o};
    check_state();
  endtask : do_step
  // trips bridge one, samples gates ten ticks into the off-time
  task automatic trip_test(input logic [1:0] share, input logic [3:0] expUp);
    int n;
    n = 0;
    @(posedge clk);
    {fastDecayShareHigh, fastDecayShareLow} <= share;
    while (upperGateOut[0] !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    senseTrip[0] <= 1'b1;
    while (upperGateOut[0] === 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    senseTrip[0] <= 1'b0;
    n = 1;
    while (upperGateOut[0] !== 1'b1 && n < 700) begin
      @(negedge clk);
      n++;
      if (n == 60)
        cmp("upper gates", {3'h0, expUp}, {3'h0, upperGateOut});
    end
    cmp("off span", 7'h1, {6'h0, n >= 522 && n <= 560});
  endtask : trip_test
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    check_state();
    trip_test(2'h3, 4'h6);
    do_step(1'b0, mst_pkg::RES_FULL);
    trip_test(2'h3, 4'h8);
    for (int r = 0; r < 4; r++)
      do_step(1'b0, 2'(r));
    for (int r = 3; r >= 0; r--)
      do_step(1'b1, 2'(r));
    ctrl.set_lines(1'b0, mst_pkg::RES_QUARTER);
    repeat (9) @(negedge clk);
    check_state();
    @(posedge clk);
    outputDisable <= 1'b1;
    repeat (5)
      do_step(1'b1, mst_pkg::RES_FULL);
    cmp("gates off", 7'h0, {3'h0, upperGateOut | lowerGateOut});
    @(posedge clk);
    outputDisable <= 1'b0;
    gateSupplyLow <= 1'b1;
    // long enough for gates to come back if the undervoltage were ignored
    repeat (60) @(negedge clk);
    cmp("supply off", 7'h0, {3'h0, upperGateOut | lowerGateOut});
    @(posedge clk);
    gateSupplyLow <= 1'b0;
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    expIdx = mst_pkg::HOME_INDEX;
    expMix = 2'h3;
    check_state();
    do_step(1'b0, mst_pkg::RES_SIXTEENTH);
    final_report();
  end
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    final_report();
  end
endmodule : tb
